// ### verilog/cssu_pkg.sv
// Package with constants and types for the clock source start-up selector.
`default_nettype none
package cssu_pkg;
  localparam logic [3:0] SEL_EXT_CLOCK = 4'h0;
  localparam logic [3:0] SEL_IRC_1M = 4'h1;
  localparam logic [3:0] SEL_IRC_8M = 4'h4;
  localparam logic [3:0] SEL_ERC_LO = 4'h5;
  localparam logic [3:0] SEL_ERC_HI = 4'h8;
  localparam logic [3:0] SEL_LF_XTAL = 4'h9;
  localparam logic [3:0] SEL_DEFAULT = 4'h1;
  localparam logic [1:0] SUT_DEFAULT = 2'h2;
  localparam logic [1:0] SUT_C0 = 2'h0;
  localparam logic [1:0] SUT_C1 = 2'h1;
  localparam logic [1:0] SUT_C2 = 2'h2;
  localparam logic [1:0] SUT_C3 = 2'h3;
  // Source cycle counts for the wake-up delay.
  localparam int unsigned CK_6 = 6;
  localparam int unsigned CK_18 = 18;
  localparam int unsigned CK_1K = 1024;
  localparam int unsigned CK_32K = 32768;
  // Watchdog oscillator cycle counts for the reset delay.
  localparam int unsigned WDT_4K = 4096;
  localparam int unsigned WDT_64K = 65536;
  localparam int unsigned CAP_PF = 36;
  localparam logic [7:0] CAL_ADDR = 8'h00;
  localparam logic [7:0] TRIM_MAX = 8'hff;
  // Wishbone register map, word aligned byte addresses.
  localparam logic [3:0] ADR_TRIM = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_FUSES = 4'h8;
  localparam logic [3:0] ADR_WAKE = 4'hc;
  localparam int unsigned CNT_W = 17;
  typedef enum logic [1:0] {
    SRC_EXT = 2'h0,
    SRC_IRC = 2'h1,
    SRC_ERC = 2'h2,
    SRC_LFX = 2'h3
  } cssu_src_t;
  typedef struct packed {
    cssu_src_t src;
    logic [1:0] band;
    logic cap_en;
    logic [CNT_W-1:0] wake_cycles;
    logic [CNT_W-1:0] reset_cycles;
  } cssu_cfg_t;
  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001,
    ST_RDLY = 4'b0010,
    ST_WAKE = 4'b0100,
    ST_RUN = 4'b1000
  } cssu_state_t;
endpackage
`default_nettype wire

// ### verilog/cssu_decode.sv
// Fuse decoder: source, band, capacitor enable and delay counts.
`default_nettype none
module cssu_decode (
  input wire logic [3:0] sel_fuses,
  input wire logic [1:0] sut_fuses,
  input wire logic opt_fuse,
  output var cssu_pkg::cssu_cfg_t cfg
);
  import cssu_pkg::*;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction

  // Reset delay: codes 00,01,10 give none, 4K, 64K; reserved gets the longest.
  function automatic logic [CNT_W-1:0] rdly(input logic [1:0] s);
    unique case (s)
      SUT_C0: return '0;
      SUT_C1: return cyc(WDT_4K);
      default: return cyc(WDT_64K);
    endcase
  endfunction

  always_comb begin
    cfg = '0;
    cfg.cap_en = ~opt_fuse;
    if (sel_fuses == SEL_EXT_CLOCK) begin
      cfg.src = SRC_EXT;
      cfg.wake_cycles = cyc(CK_6);
      cfg.reset_cycles = rdly(sut_fuses);
    end else if (sel_fuses <= SEL_IRC_8M) begin
      cfg.src = SRC_IRC;
      cfg.band = 2'(sel_fuses - SEL_IRC_1M);
      cfg.cap_en = 1'b0;
      cfg.wake_cycles = cyc(CK_6);
      cfg.reset_cycles = rdly(sut_fuses);
    end else if (sel_fuses <= SEL_ERC_HI) begin
      cfg.src = SRC_ERC;
      cfg.band = 2'(sel_fuses - SEL_ERC_LO);
      if (sut_fuses == SUT_C3) begin
        cfg.wake_cycles = cyc(CK_6);
        cfg.reset_cycles = cyc(WDT_4K);
      end else begin
        cfg.wake_cycles = cyc(CK_18);
        cfg.reset_cycles = rdly(sut_fuses);
      end
    end else begin
      // Codes above the low-frequency crystal are out of scope; treated as it.
      cfg.src = SRC_LFX;
      if (sut_fuses == SUT_C0) begin
        cfg.wake_cycles = cyc(CK_1K);
        cfg.reset_cycles = cyc(WDT_4K);
      end else if (sut_fuses == SUT_C1) begin
        cfg.wake_cycles = cyc(CK_1K);
        cfg.reset_cycles = cyc(WDT_64K);
      end else begin
        cfg.wake_cycles = cyc(CK_32K);
        cfg.reset_cycles = cyc(WDT_64K);
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/cssu_top.sv
// Clock source selection, start-up sequencing and oscillator trim register.
// Functional notes
// - Select code 1001 picks the low-frequency watch crystal.
// - Programmed option fuse switches in 36 pF internal crystal capacitors, except with internal RC selected.
// - Low-frequency crystal: 1K or 32K wake cycles, reserved code 11.
// - External RC codes 0101 to 1000 choose four frequency bands.
// - External RC: 18 source cycles, code 11 gives 6 plus 4.1 ms.
// - Codes 0001 to 0100 pick internal RC at 1, 2, 4, 8 MHz.
// - Internal RC: 6 wake cycles, reset delay none, 4.1 or 65 ms.
// - Every reset copies calibration byte at 0x00 into the trim register.
// - Larger trim value means higher internal oscillator frequency.
// - Memory write timing derives from the calibrated internal oscillator.
// - Watchdog and reset time-out stay on the watchdog oscillator.
// - Select code 0000 takes an external clock on the crystal input.
// - External clock: 6 wake cycles, reset delay none, 4.1 or 65 ms.
// - Wake counts source cycles; reset delay counts 4K or 64K watchdog cycles.
// - A fuse bit of one is unprogrammed, zero is programmed.
//
// The Wishbone register port and the register offsets were left to the implementer.
`default_nettype none
module cssu_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] sel_fuses,
  input wire logic [1:0] sut_fuses,
  input wire logic opt_fuse,
  input wire logic src_clk_pin,
  input wire logic wdt_osc_pin,
  input wire logic wake_req,
  input wire logic [7:0] cal_byte,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] cal_addr,
  output logic [7:0] trim_value,
  output logic [1:0] clk_source,
  output logic [1:0] clk_band,
  output logic cap_enable,
  output logic mem_timing_src_irc,
  output logic cpu_run
);
  import cssu_pkg::*;

  cssu_cfg_t cfg;
  cssu_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] src_sync_q, wdt_sync_q, wake_sync_q;
  logic src_lvl_q, wdt_lvl_q, wake_lvl_q;
  logic src_lvl_d, wdt_lvl_d, wake_lvl_d;
  logic [7:0] trim_q, trim_d;
  logic [31:0] dat_d;
  logic ack_q, ack_d;
  cssu_cfg_t cfg_q, cfg_d;
  logic src_tick, wdt_tick, wake_rise;
  logic wb_req;

  cssu_decode u_decode (
    .sel_fuses(sel_fuses),
    .sut_fuses(sut_fuses),
    .opt_fuse(opt_fuse),
    .cfg(cfg)
  );

  // A pin level counts once the second and third stages agree.
  function automatic logic filt(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[1] : old;
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_sync_q <= '0;
      wdt_sync_q <= '0;
      wake_sync_q <= '0;
    end else begin
      src_sync_q <= {src_sync_q[1:0], src_clk_pin};
      wdt_sync_q <= {wdt_sync_q[1:0], wdt_osc_pin};
      wake_sync_q <= {wake_sync_q[1:0], wake_req};
    end
  end

  always_comb begin
    src_lvl_d = filt(src_sync_q, src_lvl_q);
    wdt_lvl_d = filt(wdt_sync_q, wdt_lvl_q);
    wake_lvl_d = filt(wake_sync_q, wake_lvl_q);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_lvl_q <= 1'b0;
      wdt_lvl_q <= 1'b0;
      wake_lvl_q <= 1'b0;
    end else begin
      src_lvl_q <= src_lvl_d;
      wdt_lvl_q <= wdt_lvl_d;
      wake_lvl_q <= wake_lvl_d;
    end
  end

  assign src_tick = src_lvl_d & ~src_lvl_q;
  assign wdt_tick = wdt_lvl_d & ~wdt_lvl_q;
  assign wake_rise = wake_lvl_d & ~wake_lvl_q;

  // Start-up sequencer. Fuses are latched at the load step so a fuse change
  // while running cannot shift the clock selection under the core.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cfg_d = cfg_q;
    unique case (st_q)
      ST_LOAD: begin
        cfg_d = cfg;
        cnt_d = cfg.reset_cycles;
        st_d = ST_RDLY;
      end
      ST_RDLY: begin
        if (cnt_q == '0) begin
          st_d = ST_RUN;
        end else if (wdt_tick) begin
          cnt_d = CNT_W'(cnt_q - 1'b1);
        end
      end
      ST_WAKE: begin
        if (cnt_q == '0) begin
          st_d = ST_RUN;
        end else if (src_tick) begin
          cnt_d = CNT_W'(cnt_q - 1'b1);
        end
      end
      ST_RUN: begin
        if (wake_rise) begin
          cnt_d = cfg_q.wake_cycles;
          st_d = ST_WAKE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_LOAD;
      cnt_q <= '0;
      cfg_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cfg_q <= cfg_d;
    end
  end

  // Trim register and Wishbone slave; reads answer one cycle after the request.
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb begin
    trim_d = trim_q;
    dat_d = '0;
    ack_d = wb_req;
    if (st_q == ST_LOAD) begin
      trim_d = cal_byte;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[3:0] == ADR_TRIM) begin
      trim_d = wb_dat_i[7:0];
    end
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i[3:0])
        ADR_TRIM: dat_d = {24'h000000, trim_q};
        ADR_STATUS: dat_d = {27'h0, cpu_run, st_q};
        ADR_FUSES: dat_d = {25'h0, opt_fuse, sut_fuses, sel_fuses};
        ADR_WAKE: dat_d = {15'h0, cnt_q};
        default: dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trim_q <= '0;
      ack_q <= 1'b0;
    end else begin
      trim_q <= trim_d;
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
      cal_addr <= CAL_ADDR;
      trim_value <= '0;
      clk_source <= '0;
      clk_band <= '0;
      cap_enable <= 1'b0;
      mem_timing_src_irc <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      wb_dat_o <= dat_d;
      wb_ack_o <= ack_d;
      cal_addr <= CAL_ADDR;
      trim_value <= trim_d;
      clk_source <= cfg_d.src;
      clk_band <= cfg_d.band;
      cap_enable <= cfg_d.cap_en;
      mem_timing_src_irc <= 1'b1;
      cpu_run <= (st_d == ST_RUN);
    end
  end
endmodule
`default_nettype wire

// ### test/cssu_props.sv
// Concurrent checks on the ports of the clock source start-up selector.
`default_nettype none
module cssu_props
  import cssu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] sel_fuses,
  input wire logic [1:0] sut_fuses,
  input wire logic opt_fuse,
  input wire logic wake_req,
  input wire logic [7:0] cal_byte,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] cal_addr,
  input wire logic [7:0] trim_value,
  input wire logic [1:0] clk_source,
  input wire logic [1:0] clk_band,
  input wire logic cap_enable,
  input wire logic mem_timing_src_irc,
  input wire logic cpu_run
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [1:0] src_exp;
  assign src_exp = (sel_fuses == 4'h0) ? SRC_EXT : (sel_fuses <= SEL_IRC_8M) ? SRC_IRC :
    (sel_fuses <= SEL_ERC_HI) ? SRC_ERC : SRC_LFX;
  a_cal_addr_zero: assert property (cal_addr == CAL_ADDR)
    else $error("cal address moved");
  a_trim_loads_cal: assert property (!$past(rstn) |-> ##2 trim_value == cal_byte)
    else $error("trim not loaded");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_src_decode: assert property (cpu_run |-> clk_source == src_exp)
    else $error("bad source");
  a_band_decode: assert property (cpu_run &&
    (src_exp == SRC_IRC || src_exp == SRC_ERC) |-> clk_band == sel_fuses[1:0] - 2'h1)
    else $error("bad band");
  a_cap_enable: assert property (cpu_run |->
    cap_enable == (!opt_fuse && src_exp != SRC_IRC))
    else $error("bad caps");
  a_mem_timing: assert property (cpu_run |-> mem_timing_src_irc)
    else $error("memory timing source");
  a_reset_hold: assert property (!$past(rstn) && sut_fuses != SUT_C0 |->
    !cpu_run [*8])
    else $error("run too early");
  a_wake_drop: assert property ($rose(wake_req) && cpu_run |-> ##[1:8] !cpu_run)
    else $error("wake ignored");
endmodule
bind cssu_top cssu_props chk_u (.core_clk(core_clk), .rstn(rstn), .sel_fuses(sel_fuses),
  .sut_fuses(sut_fuses), .opt_fuse(opt_fuse), .wake_req(wake_req), .cal_byte(cal_byte),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cal_addr(cal_addr),
  .trim_value(trim_value), .clk_source(clk_source), .clk_band(clk_band),
  .cap_enable(cap_enable), .mem_timing_src_irc(mem_timing_src_irc), .cpu_run(cpu_run));
`default_nettype wire

// ### test/cssu_osc_model.sv
// Free-running source and watchdog oscillators with rising edge counters.
`default_nettype none
module cssu_osc_model (
  output logic src_clk,
  output logic wdt_clk,
  output int src_n,
  output int wdt_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    src_clk = 1'b0;
    wdt_clk = 1'b0;
    src_n = 0;
    wdt_n = 0;
  end
  // A fixed period never steps between cycles, so no reset hold is needed.
  // Each phase spans at least two core clock samples, else the pin filter drops it.
  always #130 src_clk = ~src_clk;
  // The watchdog oscillator runs apart from every selectable source.
  always #100 wdt_clk = ~wdt_clk;
  always @(posedge src_clk) src_n <= src_n + 1;
  always @(posedge wdt_clk) wdt_n <= wdt_n + 1;
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the clock source start-up selector.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cssu_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, opt = 1'b1, wake = 1'b0, we = 1'b0, cyc = 1'b0;
  logic stb = 1'b0, ack, cap, mts, run, sclk, wclk;
  logic [3:0] sel = 4'h1, wsel = 4'h0;
  logic [1:0] startup_time_fuses = 2'h2, src, band;
  logic [7:0] cal = 8'h00, caddr, trim;
  logic [31:0] adr = 32'h0, dat = 32'h0, rdat, rd;
  int sn, wn, miscompares = 0, tests_run = 0, cyc_n = 0;
  cssu_osc_model osc_u (.src_clk(sclk), .wdt_clk(wclk), .src_n(sn), .wdt_n(wn));
  cssu_top dut_u (.core_clk(core_clk), .rstn(rstn), .sel_fuses(sel), .sut_fuses(startup_time_fuses),
    .opt_fuse(opt), .src_clk_pin(sclk), .wdt_osc_pin(wclk), .wake_req(wake), .cal_byte(cal),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(wsel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .cal_addr(caddr), .trim_value(trim),
    .clk_source(src), .clk_band(band), .cap_enable(cap), .mem_timing_src_irc(mts),
    .cpu_run(run));
  always #25 core_clk = ~core_clk;
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 90000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    adr <= {28'h0, a};
    dat <= d;
    wsel <= s;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    // Only the bench timeout ends a wait for an answer that never comes.
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_run(input logic v);
    while (run !== v) begin
      @(posedge core_clk);
    end
  endtask
  task automatic run_case(input logic [3:0] s, input logic [1:0] u, input logic o);
    logic [1:0] es;
    int er, ew, n0;
    es = (s == 4'h0) ? SRC_EXT : (s <= SEL_IRC_8M) ? SRC_IRC :
      (s <= SEL_ERC_HI) ? SRC_ERC : SRC_LFX;
    er = (u == SUT_C0) ? 0 : (u == SUT_C1 || (u == SUT_C3 && es == SRC_ERC)) ? WDT_4K : WDT_64K;
    if (es == SRC_LFX && u < SUT_C2) er = (u == SUT_C0) ? WDT_4K : WDT_64K;
    ew = (es == SRC_LFX) ? CK_1K : (es == SRC_ERC && u != SUT_C3) ? CK_18 : CK_6;
    rstn <= 1'b0;
    sel <= s;
    startup_time_fuses <= u;
    opt <= o;
    cal <= {4'h3, s};
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    n0 = wn;
    wait_run(1'b1);
    chk(32'(wn - n0 >= er && wn - n0 <= er + 3), 32'h1);
    chk({30'h0, src}, {30'h0, es});
    chk({31'h0, cap}, {31'h0, !o && es != SRC_IRC});
    if (es == SRC_IRC || es == SRC_ERC) chk({30'h0, band}, {30'h0, s[1:0] - 2'h1});
    chk({24'h0, trim}, {28'h3, s});
    chk({24'h0, caddr}, 32'h0);
    chk({31'h0, mts}, 32'h1);
    wb(1'b0, ADR_FUSES, 32'h0, 4'hf);
    chk(rd, {25'h0, o, u, s});
    wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
    chk(rd, 32'h18);
    wake <= 1'b1;
    wait_run(1'b0);
    n0 = sn;
    wait_run(1'b1);
    chk(32'(sn - n0 >= ew - 1 && sn - n0 <= ew + 2), 32'h1);
    wake <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 10; i++) run_case(4'(i), SUT_C0, i[0]);
    run_case(SEL_IRC_1M, SUT_C1, 1'b1);
    run_case(SEL_ERC_LO, SUT_C3, 1'b0);
    wb(1'b1, ADR_TRIM, 32'hff, 4'h1);
    wb(1'b0, ADR_TRIM, 32'h0, 4'hf);
    chk(rd, 32'hff);
    wb(1'b1, ADR_TRIM, 32'h00, 4'h0);
    wb(1'b1, ADR_FUSES, 32'h0, 4'hf);
    wb(1'b0, ADR_TRIM, 32'h0, 4'hf);
    chk(rd, 32'hff);
    wb(1'b0, ADR_FUSES, 32'h0, 4'hf);
    chk(rd, {25'h0, 1'b0, SUT_C3, SEL_ERC_LO});
    wb(1'b0, 4'h6, 32'h0, 4'hf);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
